// *** src/mqpc_pkg.sv ***
// constants for the mouse quadrature position counter
package mqpc_pkg;
   localparam int   COUNT_WIDTH    = 8;
   localparam int   BUTTON_COUNT   = 3;
   localparam int   AXIS_INPUTS    = 4;
   localparam int   WORD_WIDTH     = 16;
   localparam int   X_LSB          = 0;
   localparam int   Y_LSB          = 8;
   localparam int   SETTLE_CYCLES  = 4;
   localparam int   SETTLE_WIDTH   = 3;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] COUNT_STEP  = 8'h01;
   localparam logic [2:0] SETTLE_ZERO = 3'h0;
endpackage : mqpc_pkg

// *** src/mqpc_shaper.sv ***
// de-bounce and square-wave shaping of one raw contact input
`timescale 1ns/100ps
`default_nettype none
module mqpc_shaper
   import mqpc_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic raw_in,
   output logic      shaped,
   output logic      rise
);
   logic                    sync_a;
   logic                    sync_b;
   logic [SETTLE_WIDTH-1:0] settle;
   logic [SETTLE_WIDTH-1:0] next_settle;
   logic                    next_shaped;
   logic                    next_rise;

   // settle counter: output follows only after a stable run
   always_comb
   begin
      next_settle = SETTLE_ZERO;
      next_shaped = shaped;
      next_rise   = 1'b0;
      if (sync_b != shaped)
      begin
         next_settle = settle + SETTLE_WIDTH'(1);
         if (settle == SETTLE_WIDTH'(SETTLE_CYCLES - 1))
         begin
            next_settle = SETTLE_ZERO;
            next_shaped = sync_b;
            next_rise   = sync_b;
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         settle <= SETTLE_ZERO;
         shaped <= 1'b0;
         rise   <= 1'b0;
      end
      else
      begin
         sync_a <= raw_in;
         sync_b <= sync_a;
         settle <= next_settle;
         shaped <= next_shaped;
         rise   <= next_rise;
      end
   end
endmodule : mqpc_shaper
`default_nettype wire

// *** src/mqpc_top.sv ***
// mouse position counters, button routing and host read word
//
// Notes on behaviour
// - every raw contact and button input is synchronised and de-bounced first
// - counters step only on leading edges of the shaped distance wave
// - distance edge clocks the axis; direction level picks up or down
// - distance leading direction counts up; direction leading counts down
// - any counter change raises the movement interrupt request
// - word read strobe drives both counts together, counts not cleared
// - shaped button states go to interrupt controller and status bits
// - read word holds X in low byte, Y in high byte
`timescale 1ns/100ps
`default_nettype none
module mqpc_top
   import mqpc_pkg::*;
(
   input  wire logic                          sys_clk,
   input  wire logic                          sys_rst,
   input  wire logic                          x_distance_pulse,
   input  wire logic                          x_direction_phase,
   input  wire logic                          y_distance_pulse,
   input  wire logic                          y_direction_phase,
   input  wire logic [mqpc_pkg::BUTTON_COUNT-1:0] button_raw,
   input  wire logic                          host_word_read_strobe,
   output logic      [mqpc_pkg::WORD_WIDTH-1:0]   read_data,
   output logic                               read_valid,
   output logic                               mouse_move_irq,
   output logic      [mqpc_pkg::BUTTON_COUNT-1:0] button_to_irq_ctrl,
   output logic      [mqpc_pkg::BUTTON_COUNT-1:0] button_status
);
   import mqpc_pkg::*;

   // ------------------------------------------------------------
   // input shaping
   // ------------------------------------------------------------
   localparam int N_IN = AXIS_INPUTS + BUTTON_COUNT;
   logic [N_IN-1:0] raw_vec;
   logic [N_IN-1:0] shaped_vec;
   logic [N_IN-1:0] rise_vec;
   assign raw_vec = {button_raw, y_direction_phase, y_distance_pulse,
                     x_direction_phase, x_distance_pulse};

   genvar gi;
   generate
      for (gi = 0; gi < N_IN; gi++)
      begin : g_shape
         mqpc_shaper u_shaper
         (
            .sys_clk (sys_clk),
            .sys_rst (sys_rst),
            .raw_in  (raw_vec[gi]),
            .shaped  (shaped_vec[gi]),
            .rise    (rise_vec[gi])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // axis counters
   // ------------------------------------------------------------
   logic [COUNT_WIDTH-1:0] x_count;
   logic [COUNT_WIDTH-1:0] y_count;
   logic [COUNT_WIDTH-1:0] next_x_count;
   logic [COUNT_WIDTH-1:0] next_y_count;
   logic                   next_irq;

   // direction low at distance rise means distance led the direction wave
   function automatic logic [COUNT_WIDTH-1:0] step_count
   (
      input logic [COUNT_WIDTH-1:0] cur,
      input logic                   edge_seen,
      input logic                   dir_level
   );
      logic [COUNT_WIDTH-1:0] res;
      res = cur;
      if (edge_seen)
         res = dir_level ? cur - COUNT_STEP : cur + COUNT_STEP;
      return res;
   endfunction : step_count

   always_comb
   begin
      next_x_count = step_count(x_count, rise_vec[0], shaped_vec[1]);
      next_y_count = step_count(y_count, rise_vec[2], shaped_vec[3]);
      next_irq = rise_vec[0] | rise_vec[2];
   end

   // ------------------------------------------------------------
   // host read word and button routing
   // ------------------------------------------------------------
   logic [WORD_WIDTH-1:0] next_read_data;
   always_comb
   begin
      next_read_data = read_data;
      // both counts in one word, held until next read
      if (host_word_read_strobe)
      begin
         next_read_data[X_LSB +: COUNT_WIDTH] = x_count;
         next_read_data[Y_LSB +: COUNT_WIDTH] = y_count;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         x_count            <= COUNT_RESET;
         y_count            <= COUNT_RESET;
         mouse_move_irq     <= 1'b0;
         read_data          <= '0;
         read_valid         <= 1'b0;
         button_to_irq_ctrl <= '0;
         button_status      <= '0;
      end
      else
      begin
         x_count            <= next_x_count;
         y_count            <= next_y_count;
         mouse_move_irq     <= next_irq;
         read_data          <= next_read_data;
         read_valid         <= host_word_read_strobe;
         button_to_irq_ctrl <= shaped_vec[N_IN-1:AXIS_INPUTS];
         button_status      <= shaped_vec[N_IN-1:AXIS_INPUTS];
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_read_word;
      @(posedge sys_clk) disable iff (sys_rst)
      host_word_read_strobe |=> read_valid &&
         read_data == {$past(y_count), $past(x_count)};
   endproperty
   a_read_word: assert property (p_read_word)
      else $error("read word does not hold both counts");

   property p_read_no_clear;
      @(posedge sys_clk) disable iff (sys_rst)
      (host_word_read_strobe && !rise_vec[0]) |=> x_count == $past(x_count);
   endproperty
   a_read_no_clear: assert property (p_read_no_clear)
      else $error("read disturbed the x count");

   property p_valid_pulse;
      @(posedge sys_clk) disable iff (sys_rst)
      read_valid |-> $past(host_word_read_strobe);
   endproperty
   a_valid_pulse: assert property (p_valid_pulse)
      else $error("read valid without a read strobe");

   property p_x_up;
      @(posedge sys_clk) disable iff (sys_rst)
      (rise_vec[0] && !shaped_vec[1]) |=>
         x_count == $past(x_count) + COUNT_STEP;
   endproperty
   a_x_up: assert property (p_x_up)
      else $error("x did not count up");

   property p_y_down;
      @(posedge sys_clk) disable iff (sys_rst)
      (rise_vec[2] && shaped_vec[3]) |=>
         y_count == $past(y_count) - COUNT_STEP;
   endproperty
   a_y_down: assert property (p_y_down)
      else $error("y did not count down");

   property p_no_edge_hold;
      @(posedge sys_clk) disable iff (sys_rst)
      !rise_vec[0] |=> x_count == $past(x_count);
   endproperty
   a_no_edge_hold: assert property (p_no_edge_hold)
      else $error("x moved without a leading edge");

   property p_y_hold;
      @(posedge sys_clk) disable iff (sys_rst)
      !rise_vec[2] |=> y_count == $past(y_count);
   endproperty
   a_y_hold: assert property (p_y_hold)
      else $error("y moved without a leading edge");

   property p_irq_on_move;
      @(posedge sys_clk) disable iff (sys_rst)
      (x_count != $past(x_count) || y_count != $past(y_count)) |->
         mouse_move_irq;
   endproperty
   a_irq_on_move: assert property (p_irq_on_move)
      else $error("counter moved without interrupt");

   property p_irq_only_step;
      @(posedge sys_clk) disable iff (sys_rst)
      mouse_move_irq |-> $past(rise_vec[0] | rise_vec[2]);
   endproperty
   a_irq_only_step: assert property (p_irq_only_step)
      else $error("interrupt without a counted step");

   property p_wrap;
      @(posedge sys_clk) disable iff (sys_rst)
      (rise_vec[0] && !shaped_vec[1] && x_count == '1) |=>
         x_count == COUNT_RESET;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("x count did not wrap");

   property p_wrap_down;
      @(posedge sys_clk) disable iff (sys_rst)
      (rise_vec[2] && shaped_vec[3] && y_count == COUNT_RESET) |=>
         y_count == '1;
   endproperty
   a_wrap_down: assert property (p_wrap_down)
      else $error("y count did not wrap below zero");

   property p_buttons;
      @(posedge sys_clk) disable iff (sys_rst)
      ##1 button_status == $past(shaped_vec[N_IN-1:AXIS_INPUTS]) &&
         button_to_irq_ctrl == button_status;
   endproperty
   a_buttons: assert property (p_buttons)
      else $error("button routing mismatch");

   property p_settle;
      @(posedge sys_clk) disable iff (sys_rst)
      $rose(shaped_vec[0]) |-> $past(x_distance_pulse, 5);
   endproperty
   a_settle: assert property (p_settle)
      else $error("distance edge taken without settling");

   c_x_up:   cover property (@(posedge sys_clk) rise_vec[0] && !shaped_vec[1]);
   c_x_down: cover property (@(posedge sys_clk) rise_vec[0] && shaped_vec[1]);
   c_read:   cover property (@(posedge sys_clk) host_word_read_strobe);
   c_both:   cover property (@(posedge sys_clk) rise_vec[0] && rise_vec[2]);
endmodule : mqpc_top
`default_nettype wire

// *** sim/mqpc_axis_model.sv ***
// contact model of one mouse axis: distance and direction wave
`timescale 1ns/100ps
`default_nettype none
module mqpc_axis_model
(
   input  wire logic sys_clk,
   output logic      distance,
   output logic      direction
);
   initial
   begin
      distance  = 1'b0;
      direction = 1'b0;
   end
   // direction set ahead of distance edge
   // one full square-wave period per step
   task automatic step(input logic down, input int hold);
      direction = down;
      repeat (hold) @(negedge sys_clk);
      distance = 1'b1;
      repeat (hold) @(negedge sys_clk);
      distance = 1'b0;
      repeat (hold) @(negedge sys_clk);
   endtask : step
   // contact chatter, far shorter than the settle time
   task automatic bounce();
      distance = 1'b1;
      repeat (2) @(negedge sys_clk);
      distance = 1'b0;
      repeat (12) @(negedge sys_clk);
   endtask : bounce
endmodule : mqpc_axis_model
`default_nettype wire

// *** sim/tb_mqpc_top.sv ***
// self-checking bench for the mouse position counter
`timescale 1ns/100ps
`default_nettype none
module tb_mqpc_top;
   import mqpc_pkg::*;
   logic                    sys_clk = 1'b0;
   logic                    sys_rst = 1'b1;
   logic                    x_dist;
   logic                    x_dir;
   logic                    y_dist;
   logic                    y_dir;
   logic [BUTTON_COUNT-1:0] button_raw = '0;
   logic                    rd_strobe = 1'b0;
   logic [WORD_WIDTH-1:0]   read_data;
   logic                    read_valid;
   logic                    irq;
   logic [BUTTON_COUNT-1:0] btn_irq;
   logic [BUTTON_COUNT-1:0] btn_stat;
   logic [7:0]              exp_x = 8'h00;
   logic [7:0]              exp_y = 8'h00;
   logic                    down;
   int                      failures = 0;
   int                      cmp_count = 0;
   int                      cycles = 0;
   int                      irq_seen = 0;
   int                      steps = 0;

   always #5 sys_clk = ~sys_clk;

   mqpc_axis_model x_mouse (.sys_clk(sys_clk), .distance(x_dist),
                            .direction(x_dir));
   mqpc_axis_model y_mouse (.sys_clk(sys_clk), .distance(y_dist),
                            .direction(y_dir));
   mqpc_top dut (
      .sys_clk(sys_clk), .sys_rst(sys_rst),
      .x_distance_pulse(x_dist), .x_direction_phase(x_dir),
      .y_distance_pulse(y_dist), .y_direction_phase(y_dir),
      .button_raw(button_raw), .host_word_read_strobe(rd_strobe),
      .read_data(read_data), .read_valid(read_valid),
      .mouse_move_irq(irq), .button_to_irq_ctrl(btn_irq),
      .button_status(btn_stat));

   task automatic final_report();
      if (failures == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report

   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   function automatic logic [7:0] step_count(logic [7:0] cur, logic dn);
      // wraps by plain eight-bit arithmetic
      return dn ? cur - COUNT_STEP : cur + COUNT_STEP;
   endfunction : step_count

   task automatic read_word();
      @(negedge sys_clk);
      rd_strobe = 1'b1;
      @(negedge sys_clk);
      rd_strobe = 1'b0;
      // read_valid stands for one cycle only: look at it now
      check("read_valid", {15'h0, read_valid}, 16'h0001);
      check("read_data", read_data, {exp_y, exp_x});
      @(negedge sys_clk);
      check("read_valid low", {15'h0, read_valid}, 16'h0000);
   endtask : read_word

   // irq pulses counted; a hang ends the run as a failure
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (irq === 1'b1)
         irq_seen <= irq_seen + 1;
      if (cycles == 30000)
      begin
         failures++;
         final_report();
      end
   end

   initial
   begin
      void'($urandom(32'h5165));
      repeat (16) @(negedge sys_clk);
      check("irq in reset", {15'h0, irq}, 16'h0000);
      sys_rst = 1'b0;
      // -----------------------------------------------------------
      // steps below zero, then random travel
      // -----------------------------------------------------------
      x_mouse.step(1'b1, 7);
      exp_x = step_count(exp_x, 1'b1);
      read_word();
      x_mouse.step(1'b0, 7);
      exp_x = step_count(exp_x, 1'b0);
      read_word();
      // both axes in one cycle, y wraps below zero, one irq pulse
      fork
         x_mouse.step(1'b0, 9);
         y_mouse.step(1'b1, 9);
      join
      exp_x = step_count(exp_x, 1'b0);
      exp_y = step_count(exp_y, 1'b1);
      read_word();
      for (int i = 0; i < 40; i++)
      begin
         down = $urandom % 2;
         if ($urandom % 2)
         begin
            x_mouse.step(down, 7 + $urandom % 6);
            exp_x = step_count(exp_x, down);
         end
         else
         begin
            y_mouse.step(down, 7 + $urandom % 6);
            exp_y = step_count(exp_y, down);
         end
         // host samples now and then, not every step
         if (i % 8 == 7)
            read_word();
      end
      steps = 43;
      read_word();
      check("irq pulses", 16'(irq_seen), 16'(steps));
      // -----------------------------------------------------------
      // chatter ignored, reads do not clear
      // -----------------------------------------------------------
      x_mouse.bounce();
      y_mouse.bounce();
      read_word();
      read_word();
      check("irq after bounce", 16'(irq_seen), 16'(steps));
      for (int i = 0; i < 4; i++)
      begin
         @(negedge sys_clk) button_raw = $urandom;
         repeat (12) @(negedge sys_clk);
         check("btn irq", 16'(btn_irq), 16'(button_raw));
         check("btn stat", 16'(btn_stat), 16'(button_raw));
      end
      // second reset in mid-run clears the counts
      sys_rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      sys_rst = 1'b0;
      exp_x = COUNT_RESET;
      exp_y = COUNT_RESET;
      read_word();
      final_report();
   end
endmodule : tb_mqpc_top
`default_nettype wire
